// ===== core/ldra_defines.svh
`ifndef LDRA_DEFINES_SVH
`define LDRA_DEFINES_SVH

// Display memory geometry
`define LDRA_ROWS 120
`define LDRA_COLS 132
`define LDRA_PAGES 15
`define LDRA_COMS 88

// Column counter lock value and reset values
`define LDRA_COL_LOCK 8'h84
`define LDRA_COL_RST 8'h00
`define LDRA_PAGE_RST 4'h0
`define LDRA_START_RST 8'h00
`define LDRA_LINE_RST 7'h00

// Status byte layout
`define LDRA_STAT_BUSY_BIT 7

// Busy time of one instruction and its cycle count, rounded up
`define LDRA_CLK_NS 4
`define LDRA_BUSY_NS 8
`define LDRA_BUSY_CYC ((`LDRA_BUSY_NS + `LDRA_CLK_NS - 1) / `LDRA_CLK_NS)

`endif

// ===== core/ldra_pkg.sv
`include "ldra_defines.svh"

package ldra_pkg;

	// Host instruction codes
	typedef enum logic [2:0] {
		LDRA_CMD_STATUS = 3'b000,
		LDRA_CMD_WRITE = 3'b001,
		LDRA_CMD_READ = 3'b010,
		LDRA_CMD_PAGE = 3'b011,
		LDRA_CMD_COLUMN = 3'b100,
		LDRA_CMD_START = 3'b101,
		LDRA_CMD_ADC = 3'b110,
		LDRA_CMD_INVERSE = 3'b111
	} ldra_cmd_e;

	typedef logic [`LDRA_COLS-1:0] ldra_row_t;

	// Display memory state
	typedef struct packed {
		ldra_row_t [`LDRA_ROWS-1:0] mem;
		logic [7:0] hrd;
		ldra_row_t row;
	} ldra_ram_s;

	// Core state
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic flt;
		logic fr;
		logic fr_prev;
		logic [6:0] line;
		logic [7:0] start;
		logic [3:0] page;
		logic [7:0] col;
		logic adc;
		logic inv;
		logic [3:0] busy_cnt;
		logic busy;
		logic rd_wait;
		logic rd_zero;
		logic rd_valid;
		logic [7:0] rd_data;
		logic seg_pend;
		logic [6:0] scan_line;
		ldra_row_t seg;
		logic [`LDRA_COMS-1:0] com_scan;
		logic [`LDRA_COMS-1:0] com_level;
	} ldra_core_s;

endpackage

// ===== core/ldra_ram.sv
`timescale 1ns/100ps
`include "ldra_defines.svh"

module ldra_ram (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [3:0] page,
	input wire logic [7:0] col,
	input wire logic [7:0] wr_data,
	output logic [7:0] hrd_data,
	input wire logic row_load,
	input wire logic [6:0] row_addr,
	output ldra_pkg::ldra_row_t row_data
);

	ldra_pkg::ldra_ram_s r_q;
	ldra_pkg::ldra_ram_s r_d;

	// Host byte is one column across the eight rows of a page
	always_comb
	begin
		r_d = r_q;
		if (rd_en)
		begin
			for (int b = 0; b < 8; b++)
				r_d.hrd[b] = r_q.mem[int'(page) * 8 + b][col];
		end
		if (wr_en)
		begin
			for (int b = 0; b < 8; b++)
				r_d.mem[int'(page) * 8 + b][col] = wr_data[b];
		end
		// Row taken from the old contents, so a same-cycle write never tears it
		if (row_load)
			r_d.row = r_q.mem[row_addr];
	end

	// State register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			r_q <= '0;
		else if (ce)
			r_q <= r_d;
	end

	assign hrd_data = r_q.hrd;
	assign row_data = r_q.row;

endmodule

// ===== core/ldra_core.sv
// Operation
// - Busy held high while instruction processes
// - Status read shows busy on top line
// - Eight-bit start line picks first common row
// - Line counter resets on frame change, counts
// - Eight-bit column counter advances per access
// - Column locks at 84 hex until set
// - Column advance never touches page register
// - Reverse setting flips column to segment order
// - Memory holds 15840 bits, one per pixel
// - Inverse mode swaps pixel on and off
// - Selected 132-bit row latched each common cycle
// - Host access never disturbs displayed row
// - Common level from scan state and frame
// - Reset clears column, page and start line
`timescale 1ns/100ps
`include "ldra_defines.svh"

module ldra_core (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic cl_pin,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_code,
	input wire logic [7:0] cmd_data,
	output logic busy_indicator,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic frame_alternation_signal,
	output logic [`LDRA_COLS-1:0] segment_outputs,
	output logic [`LDRA_COMS-1:0] com_scan,
	output logic [`LDRA_COMS-1:0] com_level
);

	// Whole core state in one register, next value beside it
	ldra_pkg::ldra_core_s s_q;
	ldra_pkg::ldra_core_s s_d;

	// Nets shared by the memory port and the next-state logic
	logic cl_edge;
	logic accept;
	logic in_range;
	logic ram_wr;
	logic ram_rd;
	logic [8:0] row_sum;
	logic [6:0] row_addr;
	logic [7:0] ram_hrd;
	ldra_pkg::ldra_row_t ram_row;

	// Filtered display clock edge; first stage only feeds the second
	// A level shorter than two clocks may be lost, so the pin needs
	// at least two clocks high and two low per display line
	assign cl_edge = (s_q.s2 == s_q.s3) && s_q.s3 && !s_q.flt;

	// Readout row wraps inside the implemented rows; nine bits hold
	// the largest start plus line before the modulo
	assign row_sum = {1'b0, s_q.start} + {2'b00, s_q.line};
	assign row_addr = 7'(row_sum % 9'(`LDRA_ROWS));

	// Busy instructions are dropped; only status passes while busy
	// A dropped instruction leaves no trace, so the host must poll
	assign accept = cmd_valid &&
		(!s_q.busy || cmd_code == ldra_pkg::LDRA_CMD_STATUS);

	// Addresses past the last column or page touch nothing
	assign in_range = (s_q.col < `LDRA_COL_LOCK) &&
		(s_q.page < 4'(`LDRA_PAGES));

	// Memory strobes; both use the page and column of this cycle
	assign ram_wr = accept && in_range &&
		cmd_code == ldra_pkg::LDRA_CMD_WRITE;
	assign ram_rd = accept && in_range &&
		cmd_code == ldra_pkg::LDRA_CMD_READ;

	// Display memory with its own registered ports
	ldra_ram u_ram (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.wr_en(ram_wr),
		.rd_en(ram_rd),
		.page(s_q.page),
		.col(s_q.col),
		.wr_data(cmd_data),
		.hrd_data(ram_hrd),
		.row_load(cl_edge),
		.row_addr(row_addr),
		.row_data(ram_row)
	);

	// Next state of the whole core
	always_comb
	begin
		s_d = s_q;
		// Display clock synchroniser and its agreement filter
		s_d.s1 = cl_pin;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		if (s_q.s2 == s_q.s3)
			s_d.flt = s_q.s3;

		// Line counter and frame alternation; the edge at the last line
		// flips the frame, and that change clears the count next cycle
		s_d.fr_prev = s_q.fr;
		if (s_q.fr != s_q.fr_prev)
			s_d.line = `LDRA_LINE_RST;
		else if (cl_edge)
		begin
			s_d.line = s_q.line + 7'h01;
			if (s_q.line == 7'(`LDRA_COMS - 1))
				s_d.fr = !s_q.fr;
		end

		// Row goes into the latch one cycle after its fetch
		// The latch then holds its row until the next display clock edge
		s_d.seg_pend = cl_edge;
		if (cl_edge)
			s_d.scan_line = s_q.line;
		if (s_q.seg_pend)
		begin
			for (int i = 0; i < `LDRA_COLS; i++)
			begin
				s_d.seg[i] = ram_row[s_q.adc ? `LDRA_COLS - 1 - i : i]
					^ s_q.inv;
			end
			for (int j = 0; j < `LDRA_COMS; j++)
			begin
				s_d.com_scan[j] = (7'(j) == s_q.scan_line);
				// Scanned line takes the opposite polarity of the others
				s_d.com_level[j] = (7'(j) == s_q.scan_line) ?
					!s_q.fr : s_q.fr;
			end
		end

		// Read data leaves one cycle after the memory fetch
		// A read past the last column or page answers zero
		s_d.rd_valid = 1'b0;
		if (s_q.rd_wait)
		begin
			s_d.rd_data = s_q.rd_zero ? 8'h00 : ram_hrd;
			s_d.rd_valid = 1'b1;
			s_d.rd_wait = 1'b0;
		end

		// Busy time runs down one count per enabled clock
		if (s_q.busy_cnt != 4'h0)
			s_d.busy_cnt = s_q.busy_cnt - 4'h1;

		// Instruction decode
		// A status read never starts or stretches the busy time
		if (accept)
		begin
			if (cmd_code != ldra_pkg::LDRA_CMD_STATUS)
				s_d.busy_cnt = 4'(`LDRA_BUSY_CYC);
			case (ldra_pkg::ldra_cmd_e'(cmd_code))
				ldra_pkg::LDRA_CMD_STATUS:
				begin
					s_d.rd_data = 8'h00;
					s_d.rd_data[`LDRA_STAT_BUSY_BIT] = s_q.busy;
					s_d.rd_valid = 1'b1;
				end
				ldra_pkg::LDRA_CMD_WRITE,
				ldra_pkg::LDRA_CMD_READ:
				begin
					if (cmd_code == ldra_pkg::LDRA_CMD_READ)
					begin
						s_d.rd_wait = 1'b1;
						s_d.rd_zero = !in_range;
					end
					// Page stays put; the counter stops at the lock value,
					// and a column set beyond it never counts on
					if (s_q.col < `LDRA_COL_LOCK)
						s_d.col = s_q.col + 8'h01;
				end
				ldra_pkg::LDRA_CMD_PAGE:
					s_d.page = cmd_data[3:0];
				ldra_pkg::LDRA_CMD_COLUMN:
					s_d.col = cmd_data;
				ldra_pkg::LDRA_CMD_START:
					s_d.start = cmd_data;
				ldra_pkg::LDRA_CMD_ADC:
					s_d.adc = cmd_data[0];
				ldra_pkg::LDRA_CMD_INVERSE:
					s_d.inv = cmd_data[0];
				default:
					s_d.rd_valid = s_d.rd_valid;
			endcase
		end

		// Busy follows the next count, so it rises the cycle after the take
		s_d.busy = (s_d.busy_cnt != 4'h0);
	end

	// State register; reset values for the addressing registers
	// The memory clears its own contents on the same reset
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q <= '0;
			s_q.col <= `LDRA_COL_RST;
			s_q.page <= `LDRA_PAGE_RST;
			s_q.start <= `LDRA_START_RST;
		end
		else if (ce)
			s_q <= s_d;
	end

	// Every output comes straight from a state flop
	assign busy_indicator = s_q.busy;
	assign rd_valid = s_q.rd_valid;
	assign rd_data = s_q.rd_data;
	assign frame_alternation_signal = s_q.fr;
	assign segment_outputs = s_q.seg;
	assign com_scan = s_q.com_scan;
	assign com_level = s_q.com_level;

endmodule

// ===== test/ldra_asserts.sv
`timescale 1ns/100ps
module ldra_asserts (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic cl_pin,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_code,
	input wire logic busy_indicator,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	input wire logic [131:0] segment_outputs,
	input wire logic [87:0] com_scan,
	input wire logic [87:0] com_level
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// Instruction taken; a busy core drops all but the status read
	logic tk;
	assign tk = cmd_valid && (!busy_indicator || cmd_code == 3'h0);

	sequence s_busy;
		busy_indicator [*2] ##1 !busy_indicator;
	endsequence

	AST_BUSY: assert property (tk && cmd_code != 3'h0 |=> s_busy)
		else $error("busy span wrong");
	AST_BSRC: assert property ($rose(busy_indicator) |->
		$past(tk && cmd_code != 3'h0)) else $error("stray busy");
	AST_STAT: assert property (tk && cmd_code == 3'h0 |=> rd_valid &&
		rd_data[7] == $past(busy_indicator)) else $error("status bad");
	AST_READ: assert property (tk && cmd_code == 3'h2 |-> ##2 rd_valid)
		else $error("read late");
	AST_ANS: assert property (rd_valid |-> $past(tk && cmd_code == 3'h0) ||
		$past(tk && cmd_code == 3'h2, 2)) else $error("stray answer");
	AST_COM: assert property (&(com_level ^ com_scan) ||
		!(|(com_level ^ com_scan))) else $error("common level");
	AST_ONE: assert property ($onehot0(com_scan))
		else $error("scan not one-hot");
	// Only a display clock edge may move the latched row
	AST_HOLD: assert property ((!cl_pin &&
		!(tk && cmd_code[2:1] == 2'b11)) [*8] |=> $stable(segment_outputs))
		else $error("row disturbed");
endmodule

bind ldra_core ldra_asserts u_ast (.clk(clk), .arst_n(arst_n),
	.cl_pin(cl_pin), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
	.busy_indicator(busy_indicator), .rd_valid(rd_valid), .rd_data(rd_data),
	.segment_outputs(segment_outputs), .com_scan(com_scan),
	.com_level(com_level));

// ===== test/ldra_host.sv
`timescale 1ns/100ps
module ldra_host (
	input wire logic clk,
	input wire logic busy_indicator,
	output logic cmd_valid = 1'b0,
	output logic [2:0] cmd_code = 3'h0,
	output logic [7:0] cmd_data = 8'h00
);
	// Polls busy rather than relying on fixed spacing
	// A busy that never clears is left to the bench's hang guard
	task op(input logic [2:0] c, input logic [7:0] d);
		@(posedge clk);
		while (c != 3'h0 && busy_indicator !== 1'b0)
		begin
			@(posedge clk);
		end
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_data <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_code <= ~c; // Idle lines never keep the last value
		cmd_data <= ~d;
	endtask
endmodule

// ===== test/ldra_core_tb.sv
`timescale 1ns/100ps
module ldra_core_tb;
	logic clk, arst_n, cl_pin, cmd_valid, busy_indicator, rd_valid, fr;
	logic [2:0] cmd_code;
	logic [7:0] cmd_data, rd_data, v;
	logic [131:0] seg;
	logic [87:0] com_scan, com_level;
	int err_count, n_tests, k;

	ldra_core dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .cl_pin(cl_pin),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.busy_indicator(busy_indicator), .rd_valid(rd_valid),
		.rd_data(rd_data), .frame_alternation_signal(fr),
		.segment_outputs(seg), .com_scan(com_scan),
		.com_level(com_level));
	ldra_host h (.clk(clk), .busy_indicator(busy_indicator),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data));

	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task chk(input string s, input logic [131:0] g, input logic [131:0] e);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask

	task test_done;
		if (err_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// A data read answers one cycle later than a status read
	task ask(input logic [2:0] c);
		h.op(c, 8'h00);
		repeat (c == 3'h2 ? 3 : 2) @(posedge clk);
		v = rd_data;
	endtask

	// Both levels held well past the input filter
	task pulse;
		cl_pin <= 1'b1;
		repeat (4) @(posedge clk);
		cl_pin <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	// Host traffic first, then a full frame of display scan
	initial
	begin
		arst_n = 1'b0;
		cl_pin = 1'b0;
		err_count = 0;
		n_tests = 0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		h.op(3'h1, 8'hA5);
		ask(3'h0);
		chk("busy", 132'(v[7]), 132'h1);
		ask(3'h0);
		chk("idle", 132'(v[7]), 132'h0);
		h.op(3'h4, 8'h83);
		h.op(3'h1, 8'h3C);
		h.op(3'h1, 8'h11);
		h.op(3'h1, 8'h22);
		h.op(3'h4, 8'h00);
		ask(3'h2);
		chk("col0", 132'(v), 132'hA5);
		ask(3'h2);
		chk("col1", 132'(v), 132'h00);
		h.op(3'h3, 8'h01);
		h.op(3'h4, 8'h83);
		ask(3'h2);
		chk("pg1", 132'(v), 132'h00);
		h.op(3'h5, 8'h76);
		for (k = 0; k < 88; k++)
		begin
			pulse;
			chk("scan", 132'(com_scan), 132'h1 << k);
			if (k == 2)
				chk("wrap", seg, 132'h1);
			if (k == 4)
			begin
				chk("row2", seg, {4'h8, 124'h0, 4'h1});
				chk("lvl0", 132'(com_level), 132'h10);
			end
		end
		chk("frame", 132'(fr), 132'h1);
		h.op(3'h5, 8'h03);
		h.op(3'h6, 8'h01);
		pulse;
		chk("rev", seg, 132'h1);
		chk("lvl1", 132'(com_level), 132'hFFFFFFFFFFFFFFFFFFFFFE);
		h.op(3'h7, 8'h01);
		pulse;
		chk("inv", seg, ~132'h1);
		// Rewrite a column of the row on show; the latch must not move
		h.op(3'h3, 8'h00);
		h.op(3'h4, 8'h83);
		h.op(3'h1, 8'h00);
		chk("hold", seg, ~132'h1);
		pulse;
		chk("new", seg, ~{4'h8, 128'h0});
		test_done;
	end

	// Hang guard, several times the expected run
	initial
	begin
		#30000;
		err_count++;
		test_done;
	end
endmodule
